// ### rtl/trace_capture_params.svh
/*
  Constants of the trace capture block: register offsets, field positions,
  reset values and timing counts.
  Assumes a 25 MHz clock and a 32-bit classic Wishbone register bus.
*/
`ifndef TRACE_CAPTURE_PARAMS_SVH
`define TRACE_CAPTURE_PARAMS_SVH

// ****************************************************************
// Clock and time tag
// ****************************************************************
`define CLK_PERIOD_NS        40
`define TICK_UNIT_NS         100
`define TICK_DEFAULT_NS      200
`define TICK_MAX_NS          6000000
`define TICK_SEL_DEFAULT     (`TICK_DEFAULT_NS / `TICK_UNIT_NS)
`define TICK_SEL_MAX         (`TICK_MAX_NS / `TICK_UNIT_NS)
`define TAG_MODULUS          2048
`define TAG_W                11

// ****************************************************************
// Trace store
// ****************************************************************
`define FRAME_DEPTH          1023
`define FRAME_W              48
`define IDX_W                10

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define REG_CTRL             8'h00
`define REG_TICK             8'h04
`define REG_BRK_PAT          8'h08
`define REG_BRK_CARE         8'h0C
`define REG_STATUS           8'h10
`define REG_IRQ_STAT         8'h14
`define REG_IRQ_MASK         8'h18
`define REG_RD_IDX           8'h1C
`define REG_RD_LO            8'h20
`define REG_RD_HI            8'h24
`define REG_START_ADR        8'h28
`define REG_STOP_ADR         8'h2C

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CTRL_BUS_CAP         0
`define CTRL_ARM             1
`define CTRL_CLEAR           2
`define CTRL_RESET           32'h0000_0001
`define IRQ_OVF              0
`define IRQ_BRK              1
`define IRQ_WRAP             2
`define IRQ_W                3

`endif

// ### rtl/trace_capture_pkg.sv
/*
  Types of the trace capture block.
  Assumes trace_capture_params.svh for the figures.
*/
package trace_capture_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_TRACE = 2'b01,
    ST_PAUSE = 2'b11
  } trace_state_e;
endpackage : trace_capture_pkg

// ### rtl/frame_store.sv
/*
  Frame memory of the trace store, one write port and one registered read.
  Assumes the writer keeps addresses below the depth.
*/
`timescale 1ns/1ps
`default_nettype none
`include "trace_capture_params.svh"
module frame_store (
  input  wire logic                  mclk_in,
  input  wire logic                  wr_in,
  input  wire logic [`IDX_W-1:0]     wr_idx_in,
  input  wire logic [`FRAME_W-1:0]   wr_data_in,
  input  wire logic [`IDX_W-1:0]     rd_idx_in,
  output logic      [`FRAME_W-1:0]   rd_data_out
);
  logic [`FRAME_W-1:0] mem [0:`FRAME_DEPTH-1];
  always_ff @(posedge mclk_in) begin
    if (wr_in) begin
      mem[wr_idx_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_idx_in];
  end
endmodule : frame_store
`default_nettype wire

// ### rtl/trace_capture_timetag.sv
/*
  Trace capture with time tag, pause level and data bus break comparator.
  Assumes target status inputs synchronous to mclk_in, and a Wishbone master.
*/
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "trace_capture_params.svh"
module trace_capture_timetag (
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Target status
  input  wire logic        exec_in,
  input  wire logic [19:0] exec_adr_in,
  input  wire logic        bus_in,
  input  wire logic        bus_wr_in,
  input  wire logic [19:0] bus_adr_in,
  input  wire logic [15:0] bus_data_in,
  output logic             halt_out,
  output logic             exec_break_out,
  output logic             bus_break_out,
  output logic             irq_out
);
  import trace_capture_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  trace_state_e        state_r, state_nxt;
  logic [31:0]         ctrl_r, ctrl_nxt;
  logic [15:0]         tick_sel_r, tick_sel_nxt;
  logic [15:0]         brk_pat_r, brk_pat_nxt;
  logic [3:0]          brk_care_r, brk_care_nxt;
  logic [19:0]         start_adr_r, start_adr_nxt;
  logic [19:0]         stop_adr_r, stop_adr_nxt;
  logic [`IRQ_W-1:0]   irq_stat_r, irq_stat_nxt;
  logic [`IRQ_W-1:0]   irq_mask_r, irq_mask_nxt;
  logic [`IDX_W-1:0]   rd_idx_r, rd_idx_nxt;
  logic [`IDX_W-1:0]   count_r, count_nxt;
  logic [`IDX_W-1:0]   head_r, head_nxt;
  logic                ovf_r, ovf_nxt;
  logic [15:0]         pre_r, pre_nxt;
  logic [`TAG_W-1:0]   tag_r, tag_nxt;
  logic [`TAG_W-1:0]   tag_base_r, tag_base_nxt;
  logic                first_r, first_nxt;
  logic [`TAG_W-1:0]   pause_r, pause_nxt;
  logic                lvl_flag_r, lvl_flag_nxt;
  logic [3:0]          level_r, level_nxt;
  logic                halt_r, halt_nxt;
  logic                xbrk_r, xbrk_nxt;
  logic                bbrk_r, bbrk_nxt;
  logic                irq_r, irq_nxt;
  logic                ack_r, ack_nxt;
  logic [31:0]         dat_r, dat_nxt;

  logic                tick;
  logic                tag_wrap;
  logic                wr_en;
  logic [`IDX_W-1:0]   wr_idx;
  logic [`FRAME_W-1:0] wr_frame;
  logic [`FRAME_W-1:0] rd_frame;
  logic [`IDX_W-1:0]   phys_idx;
  logic [3:0]          nib_hit;
  logic                bus_match;
  logic                bus_take;
  logic                exec_take;
  logic                wb_req;
  logic [31:0]         wmask;
  logic [`IDX_W:0]     idx_sum;
  logic [15:0]         div_r, div_nxt;
  logic                tag_step;

  // ****************************************************************
  // Frame memory
  // ****************************************************************
  frame_store u_store (
    .mclk_in     (mclk_in),
    .wr_in       (wr_en),
    .wr_idx_in   (wr_idx),
    .wr_data_in  (wr_frame),
    .rd_idx_in   (phys_idx),
    .rd_data_out (rd_frame)
  );

  // ****************************************************************
  // Break comparator, one nibble per lane slice
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_nib
      assign nib_hit[g] = ~brk_care_r[g] |
        (bus_data_in[4*g+3:4*g] == brk_pat_r[4*g+3:4*g]);
    end
  endgenerate

  // Lanes are compared as driven: even byte low, odd byte high
  assign bus_match = bus_in & bus_wr_in & (&nib_hit) & (|brk_care_r);

  assign wb_req = cyc_i & stb_i & ~ack_r;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{sel_i[i]}};
    end
  end

  // Logical index i maps to the physical slot past the oldest
  assign idx_sum  = {1'b0, rd_idx_r} + {1'b0, head_r};
  assign phys_idx = !ovf_r ? rd_idx_r :
    (idx_sum >= 11'(`FRAME_DEPTH)) ?
    10'(idx_sum - 11'(`FRAME_DEPTH)) : idx_sum[`IDX_W-1:0];

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    state_nxt     = state_r;
    ctrl_nxt      = ctrl_r;
    tick_sel_nxt  = tick_sel_r;
    brk_pat_nxt   = brk_pat_r;
    brk_care_nxt  = brk_care_r;
    start_adr_nxt = start_adr_r;
    stop_adr_nxt  = stop_adr_r;
    irq_stat_nxt  = irq_stat_r;
    irq_mask_nxt  = irq_mask_r;
    rd_idx_nxt    = rd_idx_r;
    count_nxt     = count_r;
    head_nxt      = head_r;
    ovf_nxt       = ovf_r;
    pre_nxt       = pre_r;
    tag_nxt       = tag_r;
    tag_base_nxt  = tag_base_r;
    first_nxt     = first_r;
    pause_nxt     = pause_r;
    lvl_flag_nxt  = lvl_flag_r;
    level_nxt     = level_r;
    halt_nxt      = halt_r;
    xbrk_nxt      = 1'b0;
    bbrk_nxt      = 1'b0;
    ack_nxt       = wb_req;
    dat_nxt       = dat_r;
    tick          = 1'b0;
    tag_wrap      = 1'b0;
    wr_en         = 1'b0;
    wr_idx        = '0;
    wr_frame      = '0;
    exec_take     = 1'b0;
    bus_take      = 1'b0;

    // Tick prescaler, one tick per 100 ns on average in 40 ns clocks
    if (pre_r + 16'(`CLK_PERIOD_NS) >= 16'(`TICK_UNIT_NS)) begin
      pre_nxt = 16'(pre_r + 16'(`CLK_PERIOD_NS) - 16'(`TICK_UNIT_NS));
      tick = 1'b1;
    end else begin
      pre_nxt = 16'(pre_r + 16'(`CLK_PERIOD_NS));
    end
    case (state_r)
      ST_IDLE: begin
        if (ctrl_r[`CTRL_ARM] && exec_in && exec_adr_in == start_adr_r) begin
          state_nxt = ST_TRACE;
          exec_take = 1'b1;
          first_nxt = 1'b1;
        end
      end
      ST_TRACE: begin
        exec_take = exec_in;
        bus_take  = bus_in & ctrl_r[`CTRL_BUS_CAP];
        if (exec_in && exec_adr_in == stop_adr_r) begin
          state_nxt = ST_PAUSE;
          pause_nxt = '0;
        end
      end
      ST_PAUSE: begin
        if (ctrl_r[`CTRL_ARM] && exec_in && exec_adr_in == start_adr_r) begin
          state_nxt = ST_TRACE;
          exec_take = 1'b1;
          if (lvl_flag_r) begin
            level_nxt    = 4'(level_r + 4'd1);
            lvl_flag_nxt = 1'b0;
            first_nxt    = 1'b1;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (!ctrl_r[`CTRL_ARM]) begin
      state_nxt = ST_IDLE;
    end

    // Free-running tag, wraps modulo 2048 by its own width
    tag_wrap = tag_step && (tag_r == 11'(`TAG_MODULUS - 1));
    if (tag_step) begin
      tag_nxt = 11'(tag_r + 11'd1);
    end
    // Pause timer and wrap flag while suspended
    if (state_r == ST_PAUSE && tag_step) begin
      pause_nxt = 11'(pause_r + 11'd1);
    end
    if (state_r == ST_PAUSE && tag_wrap) begin
      lvl_flag_nxt = 1'b1;
    end

    // Frame write: one frame per capture, exec wins over bus in a cycle
    if (exec_take || bus_take) begin
      wr_en = 1'b1;
      if (first_nxt) begin
        tag_base_nxt = tag_r;
        first_nxt    = 1'b0;
      end
      wr_frame = {1'b0, exec_take, level_nxt[1:0],
                  exec_take ? exec_adr_in[15:0] : bus_data_in,
                  exec_take ? 4'd0 : bus_adr_in[19:16],
                  11'(tag_r - tag_base_nxt),
                  1'b0, exec_take ? 12'd0 : bus_adr_in[11:0]};
      if (!ovf_r) begin
        wr_idx    = count_r;
        count_nxt = 10'(count_r + 10'd1);
        if (count_r == 10'(`FRAME_DEPTH - 1)) begin
          ovf_nxt  = 1'b1;
          head_nxt = '0;
        end
      end else begin
        wr_idx   = head_r;
        head_nxt = (head_r == 10'(`FRAME_DEPTH - 1)) ? '0 : 10'(head_r + 10'd1);
      end
    end

    // Breaks
    if (exec_in && exec_adr_in == stop_adr_r && ctrl_r[3]) begin
      halt_nxt = 1'b1;
      xbrk_nxt = 1'b1;
    end
    if (bus_match) begin
      halt_nxt = 1'b1;
      bbrk_nxt = 1'b1;
    end

    // Register bus
    if (wb_req && we_i) begin
      case (adr_i)
        `REG_CTRL: begin
          ctrl_nxt = (ctrl_r & ~wmask) | (dat_i & wmask);
          if (sel_i[0] && dat_i[`CTRL_CLEAR]) begin
            count_nxt = '0;
            head_nxt  = '0;
            ovf_nxt   = 1'b0;
            halt_nxt  = 1'b0;
            level_nxt = '0;
            first_nxt = 1'b1;
          end
          ctrl_nxt[`CTRL_CLEAR] = 1'b0;
        end
        `REG_TICK: begin
          if (sel_i[1:0] == 2'b11 && dat_i[15:0] != 16'd0
              && dat_i[15:0] <= 16'(`TICK_SEL_MAX)) begin
            tick_sel_nxt = dat_i[15:0];
          end
        end
        `REG_BRK_PAT:   brk_pat_nxt  = dat_i[15:0];
        `REG_BRK_CARE:  brk_care_nxt = dat_i[3:0];
        `REG_IRQ_STAT:  irq_stat_nxt = irq_stat_r & ~dat_i[`IRQ_W-1:0];
        `REG_IRQ_MASK:  irq_mask_nxt = dat_i[`IRQ_W-1:0];
        `REG_RD_IDX:    rd_idx_nxt   = dat_i[`IDX_W-1:0];
        `REG_START_ADR: start_adr_nxt = dat_i[19:0];
        `REG_STOP_ADR:  stop_adr_nxt  = dat_i[19:0];
        default: ;
      endcase
    end
    if (wb_req && !we_i) begin
      case (adr_i)
        `REG_CTRL:      dat_nxt = ctrl_r;
        `REG_TICK:      dat_nxt = {16'd0, tick_sel_r};
        `REG_BRK_PAT:   dat_nxt = {16'd0, brk_pat_r};
        `REG_BRK_CARE:  dat_nxt = {28'd0, brk_care_r};
        `REG_STATUS:    dat_nxt = {8'd0, level_r, 1'b0, lvl_flag_r, halt_r,
                                   ovf_r, state_r, count_r, 4'd0};
        `REG_IRQ_STAT:  dat_nxt = {29'd0, irq_stat_r};
        `REG_IRQ_MASK:  dat_nxt = {29'd0, irq_mask_r};
        `REG_RD_IDX:    dat_nxt = {22'd0, rd_idx_r};
        `REG_RD_LO:     dat_nxt = rd_frame[31:0];
        `REG_RD_HI:     dat_nxt = {16'd0, rd_frame[47:32]};
        `REG_START_ADR: dat_nxt = {12'd0, start_adr_r};
        `REG_STOP_ADR:  dat_nxt = {12'd0, stop_adr_r};
        default:        dat_nxt = 32'h0000_0000;
      endcase
    end

    // Sticky events, set wins over a same-cycle clear
    irq_stat_nxt[`IRQ_OVF]  = irq_stat_nxt[`IRQ_OVF] | (ovf_nxt & ~ovf_r);
    irq_stat_nxt[`IRQ_BRK]  = irq_stat_nxt[`IRQ_BRK] | bbrk_nxt | xbrk_nxt;
    irq_stat_nxt[`IRQ_WRAP] = irq_stat_nxt[`IRQ_WRAP] | (lvl_flag_nxt & ~lvl_flag_r);
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
  end

  // ****************************************************************
  // Time tag counter: one count per tick_sel x 100 ns
  // ****************************************************************
  always_comb begin
    div_nxt  = div_r;
    tag_step = 1'b0;
    if (tick) begin
      if (div_r + 16'd1 >= tick_sel_r) begin
        div_nxt  = '0;
        tag_step = 1'b1;
      end else begin
        div_nxt = 16'(div_r + 16'd1);
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      state_r     <= ST_IDLE;
      ctrl_r      <= `CTRL_RESET;
      tick_sel_r  <= 16'(`TICK_SEL_DEFAULT);
      brk_pat_r   <= 16'h0000;
      brk_care_r  <= 4'h0;
      start_adr_r <= 20'h00000;
      stop_adr_r  <= 20'h00000;
      irq_stat_r  <= '0;
      irq_mask_r  <= '0;
      rd_idx_r    <= '0;
      count_r     <= '0;
      head_r      <= '0;
      ovf_r       <= 1'b0;
      pre_r       <= 16'h0000;
      div_r       <= 16'h0000;
      tag_r       <= '0;
      tag_base_r  <= '0;
      first_r     <= 1'b1;
      pause_r     <= '0;
      lvl_flag_r  <= 1'b0;
      level_r     <= 4'h0;
      halt_r      <= 1'b0;
      xbrk_r      <= 1'b0;
      bbrk_r      <= 1'b0;
      irq_r       <= 1'b0;
      ack_r       <= 1'b0;
      dat_r       <= 32'h0000_0000;
    end else begin
      state_r     <= state_nxt;
      ctrl_r      <= ctrl_nxt;
      tick_sel_r  <= tick_sel_nxt;
      brk_pat_r   <= brk_pat_nxt;
      brk_care_r  <= brk_care_nxt;
      start_adr_r <= start_adr_nxt;
      stop_adr_r  <= stop_adr_nxt;
      irq_stat_r  <= irq_stat_nxt;
      irq_mask_r  <= irq_mask_nxt;
      rd_idx_r    <= rd_idx_nxt;
      count_r     <= count_nxt;
      head_r      <= head_nxt;
      ovf_r       <= ovf_nxt;
      pre_r       <= pre_nxt;
      div_r       <= div_nxt;
      tag_r       <= tag_nxt;
      tag_base_r  <= tag_base_nxt;
      first_r     <= first_nxt;
      pause_r     <= pause_nxt;
      lvl_flag_r  <= lvl_flag_nxt;
      level_r     <= level_nxt;
      halt_r      <= halt_nxt;
      xbrk_r      <= xbrk_nxt;
      bbrk_r      <= bbrk_nxt;
      irq_r       <= irq_nxt;
      ack_r       <= ack_nxt;
      dat_r       <= dat_nxt;
    end
  end

  assign halt_out       = halt_r;
  assign exec_break_out = xbrk_r;
  assign bus_break_out  = bbrk_r;
  assign irq_out        = irq_r;
  assign ack_o          = ack_r;
  assign dat_o          = dat_r;

endmodule : trace_capture_timetag
`default_nettype wire

// ### dv/trace_capture_asserts.sv
/*
  Port checker of the trace capture block, with its bind.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module trace_capture_asserts (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic ack_o,
  input wire logic exec_in,
  input wire logic bus_in,
  input wire logic bus_wr_in,
  input wire logic halt_out,
  input wire logic exec_break_out,
  input wire logic bus_break_out,
  input wire logic irq_out
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ack;
    ack_o ##1 !ack_o;
  endsequence
  property p_wb_ack;
    s_req |=> s_ack;
  endproperty
  property p_brk_pulse;
    bus_break_out |=> !bus_break_out;
  endproperty
  property p_brk_cause;
    bus_break_out |-> $past(bus_in && bus_wr_in);
  endproperty
  property p_exec_pulse;
    exec_break_out |=> !exec_break_out;
  endproperty
  property p_exec_cause;
    exec_break_out |-> $past(exec_in);
  endproperty
  property p_halt_set;
    (bus_break_out || exec_break_out) |-> ##[0:1] halt_out;
  endproperty
  property p_halt_hold;
    halt_out && !(cyc_i && stb_i && we_i) && !$past(cyc_i && stb_i && we_i)
      |=> halt_out;
  endproperty
  property p_rst_quiet;
    disable iff (1'b0)
    !nrst_in |=> !halt_out && !irq_out && !ack_o && !bus_break_out;
  endproperty
  a_wb_ack: assert property (p_wb_ack)
    else $error("ack not one cycle after request");
  a_brk_pulse: assert property (p_brk_pulse)
    else $error("bus break longer than one cycle");
  a_brk_cause: assert property (p_brk_cause)
    else $error("bus break without bus write");
  a_exec_pulse: assert property (p_exec_pulse)
    else $error("exec break longer than one cycle");
  a_exec_cause: assert property (p_exec_cause)
    else $error("exec break without exec cycle");
  a_halt_set: assert property (p_halt_set)
    else $error("break without halt");
  a_halt_hold: assert property (p_halt_hold)
    else $error("halt dropped without a write");
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("output active after reset");
endmodule : trace_capture_asserts

bind trace_capture_timetag trace_capture_asserts i_chk (.mclk_in, .nrst_in,
  .cyc_i, .stb_i, .we_i, .ack_o, .exec_in, .bus_in, .bus_wr_in, .halt_out,
  .exec_break_out, .bus_break_out, .irq_out);
`default_nettype wire

// ### dv/target_bus_model.sv
/*
  Target processor model: execution strobes and data bus cycles.
  Its tasks are called by the bench just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module target_bus_model (
  input  wire logic        mclk_in,
  output var  logic        exec_out,
  output var  logic [19:0] exec_adr_out,
  output var  logic        bus_out,
  output var  logic        bus_wr_out,
  output var  logic [19:0] bus_adr_out,
  output var  logic [15:0] bus_data_out
);
  // ****************************************************************
  // Cycles
  // ****************************************************************
  initial begin
    exec_out = 1'b0;
    exec_adr_out = 20'h00000;
    bus_out = 1'b0;
    bus_wr_out = 1'b0;
    bus_adr_out = 20'h00000;
    bus_data_out = 16'h0000;
  end
  task automatic exec(input logic [19:0] a);
    exec_out <= 1'b1;
    exec_adr_out <= a;
    @(posedge mclk_in);
    exec_out <= 1'b0;
    exec_adr_out <= ~a;
    @(posedge mclk_in);
  endtask : exec
  task automatic bus_cyc(input logic w, input logic [19:0] a,
                         input logic [15:0] d);
    bus_out <= 1'b1;
    bus_wr_out <= w;
    bus_adr_out <= a;
    bus_data_out <= d;
    @(posedge mclk_in);
    bus_out <= 1'b0;
    bus_adr_out <= ~a;
    bus_data_out <= ~d;
    @(posedge mclk_in);
  endtask : bus_cyc
  task automatic wr_word(input logic [19:0] a, input logic [15:0] w);
    if (!a[0]) begin
      bus_cyc(1'b1, a, w);
    end else begin
      bus_cyc(1'b1, a, {w[7:0], w[15:8]});
      bus_cyc(1'b1, a + 20'h00001, {w[7:0], w[15:8]});
    end
  endtask : wr_word
  task automatic wr_byte(input logic [19:0] a, input logic [7:0] b);
    bus_cyc(1'b1, a, a[0] ? {b, ~b} : {~b, b});
  endtask : wr_byte
endmodule : target_bus_model
`default_nettype wire

// ### dv/tb_top.sv
/*
  Self-checking bench of the trace capture block.
  Assumes the params header, the checker and the target bus model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "trace_capture_params.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb_top;
  import trace_capture_pkg::*;
  localparam logic [19:0] START = 20'h00100;
  localparam logic [19:0] STOP  = 20'h00200;
  logic        mclk_in, nrst_in, cyc_i, stb_i, we_i, ack_o;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic        exec_in, bus_in, bus_wr_in, irq_out;
  logic        halt_out, exec_break_out, bus_break_out;
  logic [19:0] exec_adr_in, bus_adr_in;
  logic [15:0] bus_data_in;
  logic [47:0] f;
  int          failures, check_count, cyc_cnt, k;
  trace_capture_timetag i_dut (.mclk_in, .nrst_in, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .exec_in, .exec_adr_in, .bus_in,
    .bus_wr_in, .bus_adr_in, .bus_data_in, .halt_out, .exec_break_out,
    .bus_break_out, .irq_out);
  target_bus_model i_tgt (.mclk_in, .exec_out(exec_in),
    .exec_adr_out(exec_adr_in), .bus_out(bus_in), .bus_wr_out(bus_wr_in),
    .bus_adr_out(bus_adr_in), .bus_data_out(bus_data_in));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge mclk_in); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge mclk_in);
  endtask : wb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask : rchk
  task automatic frm(input int i);
    wb(1'b1, `REG_RD_IDX, 32'(i));
    @(posedge mclk_in);
    wb(1'b0, `REG_RD_LO, 32'h0);
    f[31:0] = q;
    wb(1'b0, `REG_RD_HI, 32'h0);
    f[47:32] = q[15:0];
  endtask : frm
  task automatic hchk(input logic e);
    repeat (4) @(posedge mclk_in);
    `CHK(halt_out, e)
  endtask : hchk
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  // ****************************************************************
  // Clock, timeout and tests
  // ****************************************************************
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cyc_cnt++;
    if (cyc_cnt == 30000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    nrst_in <= 1'b0;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    adr_i <= 8'h00;
    sel_i <= 4'hF;
    dat_i <= 32'h0;
    repeat (2) @(posedge mclk_in);
    nrst_in <= 1'b1;
    @(posedge mclk_in);
    rchk(`REG_CTRL, 32'h1);
    rchk(`REG_TICK, 32'h2);
    wb(1'b1, `REG_TICK, 32'h0);
    rchk(`REG_TICK, 32'h2);
    wb(1'b1, `REG_TICK, 32'h0000EA60);
    rchk(`REG_TICK, 32'h0000EA60);
    wb(1'b1, `REG_TICK, 32'h0000EA61);
    rchk(`REG_TICK, 32'h0000EA60);
    wb(1'b1, `REG_TICK, 32'h2);
    rchk(8'hFC, 32'h0);
    rchk(`REG_IRQ_STAT, 32'h0);
    done("registers");
    wb(1'b1, `REG_START_ADR, {12'h000, START});
    wb(1'b1, `REG_STOP_ADR, {12'h000, STOP});
    wb(1'b1, `REG_IRQ_MASK, 32'h1);
    wb(1'b1, `REG_CTRL, 32'h3);
    i_tgt.exec(START);
    i_tgt.wr_word(20'h00400, 16'h1000);
    frm(0);
    `CHK(f[23:13], 11'h000)
    `CHK(f[46], 1'b1)
    frm(1);
    `CHK({f[46], f[43:28]}, 17'h01000)
    for (k = 1; k < 1040; k++) begin
      i_tgt.wr_word(20'h00400, 16'h1000 + 16'(k));
      if (k == 1020 || k == 1021) begin
        wb(1'b0, `REG_IRQ_STAT, 32'h0);
        `CHK(q[0], k == 1021)
      end
    end
    `CHK(irq_out, 1'b1)
    frm(0);
    `CHK(f[43:28], 16'h1011)
    frm(1022);
    `CHK(f[43:28], 16'h140F)
    wb(1'b1, `REG_IRQ_STAT, 32'h1);
    rchk(`REG_IRQ_STAT, 32'h0);
    `CHK(irq_out, 1'b0)
    done("capture");
    wb(1'b1, `REG_IRQ_STAT, 32'h7);
    i_tgt.exec(STOP);
    repeat (11000) @(posedge mclk_in);
    wb(1'b0, `REG_IRQ_STAT, 32'h0);
    `CHK(q[2], 1'b1)
    wb(1'b1, `REG_CTRL, 32'h2);
    i_tgt.exec(START);
    repeat (48) @(posedge mclk_in);
    i_tgt.exec(20'h00150);
    i_tgt.wr_word(20'h00400, 16'h2222);
    frm(1021);
    `CHK(f[23:13], 11'h000)
    frm(1022);
    `CHK({f[46], f[23:13]}, 12'h80A)
    done("pause");
    i_tgt.exec(STOP);
    wb(1'b1, `REG_BRK_PAT, 32'h0000AB00);
    wb(1'b1, `REG_BRK_CARE, 32'hC);
    wb(1'b1, `REG_IRQ_MASK, 32'h0);
    wb(1'b1, `REG_IRQ_STAT, 32'h7);
    i_tgt.wr_word(20'h0FC01, 16'hAB12);
    hchk(1'b0);
    i_tgt.bus_cyc(1'b0, 20'h0FC00, 16'hAB12);
    hchk(1'b0);
    i_tgt.wr_word(20'h0FC00, 16'hAB12);
    hchk(1'b1);
    wb(1'b0, `REG_IRQ_STAT, 32'h0);
    `CHK({q[1], irq_out}, 2'b10)
    wb(1'b1, `REG_IRQ_MASK, 32'h2);
    repeat (2) @(posedge mclk_in);
    `CHK(irq_out, 1'b1)
    wb(1'b1, `REG_IRQ_STAT, 32'h2);
    repeat (2) @(posedge mclk_in);
    `CHK(irq_out, 1'b0)
    wb(1'b1, `REG_CTRL, 32'h4);
    hchk(1'b0);
    i_tgt.wr_byte(20'h0FC00, 8'hAB);
    hchk(1'b0);
    i_tgt.wr_byte(20'h0FC01, 8'hAB);
    hchk(1'b1);
    wb(1'b1, `REG_CTRL, 32'hC);
    hchk(1'b0);
    i_tgt.exec(20'h00150);
    hchk(1'b0);
    i_tgt.exec(STOP);
    hchk(1'b1);
    done("breaks");
    nrst_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    nrst_in <= 1'b1;
    @(posedge mclk_in);
    `CHK(halt_out, 1'b0)
    rchk(`REG_CTRL, 32'h1);
    done("reset");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
